// ### fcs_bus_cycle.sv
// one flash bus cycle, read or write, on the asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module fcs_bus_cycle #(
  parameter int WE_CYC = fcs_pkg::WE_LOW_CYC,
  parameter int RD_CYC = fcs_pkg::RD_ACC_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic start,
  input wire fcs_pkg::fcs_cyc_t req,
  output logic ready,
  output logic done,
  output logic [7:0] rdata,
  output logic [20:0] flashAddr,
  output logic [7:0] flashDqOut,
  input wire logic [7:0] flashDqIn,
  output logic flashDqOen,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN
);
  // read strobe covers access time plus the data synchroniser
  localparam int RD_LEN = RD_CYC + fcs_pkg::SYNC_CYC;
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001, C_SETUP = 4'b0010, C_STROBE = 4'b0100, C_HOLD = 4'b1000
  } fcs_cst_t;
  fcs_cst_t state, next_state;
  fcs_pkg::fcs_cyc_t cur;
  logic [3:0] cnt;
  logic [7:0] dqMeta, dqSync;

  wire inStrobe = state == C_STROBE;
  wire strobeEnd = inStrobe && (cnt == 4'h0);
  assign ready = state == C_IDLE;
  assign done = state == C_HOLD;
  assign flashAddr = cur.addr;
  assign flashDqOut = cur.data;
  // data driven from setup through hold of a write
  assign flashDqOen = ready || cur.isRead; // see R02
  assign flashCeN = !inStrobe;
  assign flashWeN = !(inStrobe && !cur.isRead);
  assign flashOeN = !(inStrobe && cur.isRead);

  always_comb begin
    next_state = state;
    unique case (state)
      C_IDLE: if (start) next_state = C_SETUP;
      C_SETUP: next_state = C_STROBE;
      C_STROBE: if (cnt == 4'h0) next_state = C_HOLD;
      C_HOLD: next_state = C_IDLE;
      default: next_state = C_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dqMeta <= 8'h00;
      dqSync <= 8'h00;
    end else if (clkEn) begin
      dqMeta <= flashDqIn;
      dqSync <= dqMeta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= C_IDLE;
      cur <= '0;
    end else if (clkEn) begin
      state <= next_state;
      // address and data stay put for the whole cycle
      if (ready && start) cur <= req; // see R02
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt <= 4'h0;
      rdata <= 8'h00;
    end else if (clkEn) begin
      if (state == C_SETUP) cnt <= cur.isRead ? 4'(RD_LEN - 1) : 4'(WE_CYC - 1);
      else if (inStrobe && cnt != 4'h0) cnt <= cnt - 4'h1;
      if (strobeEnd && cur.isRead) rdata <= dqSync;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk iff clkEn); endclocking
  default disable iff (!nrst);
  a_we_pulse_len: assert property ($fell(flashWeN) |-> !flashWeN [*2] ##1 flashWeN) // see R02
    else $error("write strobe width wrong");
  a_dq_drive_we: assert property (!flashWeN |-> !flashDqOen && $past(!flashDqOen)) // see R02
    else $error("data not driven around write strobe");
  a_addr_held: assert property (!flashCeN && $past(!flashCeN) |-> $stable(flashAddr)) // see R02
    else $error("address moved during strobe");
  a_strobe_excl: assert property (!(!flashWeN && !flashOeN))
    else $error("write and output enable together");
  c_read_cycle: cover property ($fell(flashOeN) ##[1:10] done);
endmodule
`default_nettype wire

// ### fcs_flash_host.sv
// apb-controlled host that sequences flash command cycles and polls status
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Function
// R01: issue only complete valid command sequences
// R02: hold address, data across whole strobe
// R03: return idle once algorithm completes
// R04: single reset write restores array read
// R05: reset before erase starts aborts
// R06: reset before programming starts aborts
// R07: leave autoselect by writing reset
// R08: timeout flag seen, host writes reset
// R09: autoselect reads need no new sequence
// R10: low byte zero/one gives identity
// R11: low byte two gives sector protection
// R12: program is four write cycles
// R13: completion seen through polling bit
// R14: hardware reset kills programming, retry
// R15: programming only clears bits
// R16: chip erase is six write cycles
// R17: chip erase ignores commands meanwhile
// R18: sector erase last write carries sector
// R19: add sectors within fifty microsecond window
// R20: other command in window cancels erase
// R21: window timed from final write strobe
// R22: running sector erase accepts only suspend
// R23: five top address bits pick sector
// R24: upper address bits ignored in unlocks
// R25: suspend ends window, suspends erase
// R26: fixed command byte values
module fcs_flash_host #(
  parameter int WIN_CYC = fcs_pkg::ERASE_WIN_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [20:0] flashAddr,
  output logic [7:0] flashDqOut,
  input wire logic [7:0] flashDqIn,
  output logic flashDqOen,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic flashResetN,
  input wire logic flashReadyBusy
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_ISSUE = 5'b00010, S_WAIT = 5'b00100,
    S_POLL = 5'b01000, S_POLLW = 5'b10000
  } fcs_sst_t;
  fcs_sst_t state, next_state;
  fcs_pkg::fcs_op_t op;
  logic [2:0] step;
  logic [20:0] addrReg;
  logic [7:0] wdataReg, rdataReg;
  logic errFlag, refused, rybyMeta, rybySync;
  logic [11:0] winCnt;
  logic cycReady, cycDone;
  logic [7:0] cycRdata;
  fcs_pkg::fcs_cyc_t cycReq;

  // -------------------------------------------------------------------
  // sequence tables
  // -------------------------------------------------------------------
  function automatic logic [2:0] nSteps(input fcs_pkg::fcs_op_t o);
    case (o)
      fcs_pkg::OP_AUTOSEL: nSteps = 3'h5;
      fcs_pkg::OP_PROGRAM: nSteps = 3'h4; // see R12
      fcs_pkg::OP_CHIP, fcs_pkg::OP_SECT: nSteps = 3'h6; // see R16
      fcs_pkg::OP_WAIT: nSteps = 3'h0;
      default: nSteps = 3'h1;
    endcase
  endfunction

  function automatic fcs_pkg::fcs_cyc_t stepReq(input fcs_pkg::fcs_op_t o,
      input logic [2:0] i, input logic [20:0] a, input logic [7:0] d);
    fcs_pkg::fcs_cyc_t c;
    // unlock addresses fixed; upper bits do not matter to the device
    c = '{isRead: 1'b0, addr: fcs_pkg::UNLOCK_ADDR1, data: fcs_pkg::CMD_UNLOCK1}; // see R24
    case (i)
      3'h1, 3'h4: begin
        c.addr = fcs_pkg::UNLOCK_ADDR2;
        c.data = fcs_pkg::CMD_UNLOCK2; // see R26
      end
      3'h2: c.data = (o == fcs_pkg::OP_AUTOSEL) ? fcs_pkg::CMD_AUTOSEL :
                     (o == fcs_pkg::OP_PROGRAM) ? fcs_pkg::CMD_PROGRAM :
                     fcs_pkg::CMD_ERASE_SETUP;
      3'h5: begin
        c.data = (o == fcs_pkg::OP_CHIP) ? fcs_pkg::CMD_CHIP : fcs_pkg::CMD_SECTOR;
        if (o == fcs_pkg::OP_SECT) c.addr = a; // see R18
      end
      default: ;
    endcase
    if (o == fcs_pkg::OP_AUTOSEL && i == 3'h3) begin
      c.isRead = 1'b1; // see R09
      c.addr = a; // see R10
    end
    if (o == fcs_pkg::OP_AUTOSEL && i == 3'h4) c.data = fcs_pkg::CMD_RESET; // see R07
    if (o == fcs_pkg::OP_PROGRAM && i == 3'h3) begin
      c.addr = a;
      c.data = d; // see R12
    end
    if (i == 3'h0) begin
      case (o)
        fcs_pkg::OP_READ: begin
          c.isRead = 1'b1;
          c.addr = a;
        end
        fcs_pkg::OP_RESET: c.data = fcs_pkg::CMD_RESET; // see R04
        fcs_pkg::OP_SECTADD: begin
          c.addr = a; // see R23
          c.data = fcs_pkg::CMD_SECTOR;
        end
        fcs_pkg::OP_SUSPEND: c.data = fcs_pkg::CMD_SUSPEND; // see R25
        fcs_pkg::OP_RESUME: c.data = fcs_pkg::CMD_RESUME;
        default: ;
      endcase
    end
    return c;
  endfunction

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire [2:0] n = nSteps(op);
  wire idle = state == S_IDLE;
  wire winOpen = winCnt != 12'h000;
  wire apbAcc = psel && penable;
  wire wrCtrl = apbAcc && pwrite && paddr == fcs_pkg::REG_CTRL;
  wire [3:0] newOp = pwdata[3:0];
  wire opLegal = newOp <= fcs_pkg::OP_WAIT;
  // a late sector add would start a partial erase
  wire lateAdd = newOp == fcs_pkg::OP_SECTADD && !winOpen; // see R19
  wire accept = wrCtrl && idle && opLegal && !lateAdd;
  wire seqDone = state == S_ISSUE && step == n;
  wire lastDone = state == S_WAIT && cycDone && step == 3'(n - 3'h1);
  wire pollOk = (op == fcs_pkg::OP_PROGRAM) ?
                cycRdata[fcs_pkg::POLL_BIT] == wdataReg[fcs_pkg::POLL_BIT] :
                cycRdata[fcs_pkg::POLL_BIT]; // see R13
  wire pollEnd = state == S_POLLW && cycDone;
  wire timedOut = pollEnd && !pollOk && cycRdata[fcs_pkg::TIMEOUT_BIT];
  wire needPoll = op == fcs_pkg::OP_PROGRAM || op == fcs_pkg::OP_CHIP ||
                  op == fcs_pkg::OP_WAIT;
  wire cycStart = cycReady && (state == S_POLL || (state == S_ISSUE && step != n));
  wire hit = paddr == fcs_pkg::REG_CTRL || paddr == fcs_pkg::REG_ADDR ||
             paddr == fcs_pkg::REG_WDATA || paddr == fcs_pkg::REG_STATUS;
  wire [31:0] statusWord = {16'h0000, rdataReg, 3'b000, rybySync, refused,
                            winOpen, errFlag, !idle};
  wire [31:0] rdMux = (paddr == fcs_pkg::REG_ADDR) ? {11'h000, addrReg} :
                      (paddr == fcs_pkg::REG_WDATA) ? {24'h000000, wdataReg} :
                      (paddr == fcs_pkg::REG_STATUS) ? statusWord : 32'h00000000;
  assign pready = 1'b1;
  assign cycReq = (state == S_POLL) ?
                  fcs_pkg::fcs_cyc_t'{isRead: 1'b1, addr: addrReg, data: 8'h00} :
                  stepReq(op, step, addrReg, wdataReg);

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (accept) next_state = S_ISSUE;
      S_ISSUE: begin
        if (seqDone) next_state = needPoll ? S_POLL : S_IDLE; // see R03
        else if (cycStart) next_state = S_WAIT;
      end
      S_WAIT: if (cycDone) next_state = S_ISSUE;
      S_POLL: if (cycStart) next_state = S_POLLW;
      S_POLLW: begin
        if (cycDone) next_state = pollOk ? S_IDLE : timedOut ? S_ISSUE : S_POLL;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // -------------------------------------------------------------------
  // sequencer and registers
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= S_IDLE;
      op <= fcs_pkg::OP_READ;
      step <= 3'h0;
    end else if (clkEn) begin
      state <= next_state;
      if (accept) begin
        op <= fcs_pkg::fcs_op_t'(newOp);
        step <= 3'h0;
      end else if (state == S_WAIT && cycDone) begin
        step <= step + 3'h1;
      end else if (timedOut) begin
        op <= fcs_pkg::OP_RESET; // see R08
        step <= 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      addrReg <= 21'h000000;
      wdataReg <= 8'h00;
      rdataReg <= 8'h00;
    end else if (clkEn) begin
      if (apbAcc && pwrite && paddr == fcs_pkg::REG_ADDR) addrReg <= pwdata[20:0];
      if (apbAcc && pwrite && paddr == fcs_pkg::REG_WDATA) wdataReg <= pwdata[7:0];
      if ((state == S_WAIT || state == S_POLLW) && cycDone) rdataReg <= cycRdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      errFlag <= 1'b0;
      refused <= 1'b0;
    end else if (clkEn) begin
      if (timedOut) errFlag <= 1'b1;
      else if (accept) errFlag <= 1'b0;
      if (wrCtrl && !accept) refused <= 1'b1;
      else if (accept) refused <= 1'b0;
    end
  end

  // window restarts at the end of each sector write; other commands close it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      winCnt <= 12'h000;
    end else if (clkEn) begin
      if (lastDone && (op == fcs_pkg::OP_SECT || op == fcs_pkg::OP_SECTADD))
        winCnt <= 12'(WIN_CYC); // see R21
      else if (accept && newOp != fcs_pkg::OP_SECTADD) winCnt <= 12'h000; // see R20
      else if (winOpen) winCnt <= winCnt - 12'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      rybyMeta <= 1'b0;
      rybySync <= 1'b0;
      flashResetN <= 1'b0;
    end else if (clkEn) begin
      if (psel && !penable) begin
        prdata <= rdMux;
        pslverr <= !hit;
      end
      rybyMeta <= flashReadyBusy;
      rybySync <= rybyMeta;
      flashResetN <= 1'b1;
    end
  end

  fcs_bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .start(cycStart),
    .req(cycReq),
    .ready(cycReady),
    .done(cycDone),
    .rdata(cycRdata),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqIn(flashDqIn),
    .flashDqOen(flashDqOen),
    .flashCeN(flashCeN),
    .flashWeN(flashWeN),
    .flashOeN(flashOeN)
  );

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk iff clkEn); endclocking
  default disable iff (!nrst);
  a_unlock_first: assert property (cycStart && state == S_ISSUE && step == 3'h0 &&
      op inside {fcs_pkg::OP_AUTOSEL, fcs_pkg::OP_PROGRAM, fcs_pkg::OP_CHIP,
      fcs_pkg::OP_SECT} |-> cycReq.data == 8'haa && !cycReq.isRead) // see R26
    else $error("sequence not opened by unlock");
  a_autosel_exit: assert property (state == S_WAIT && cycDone && op == fcs_pkg::OP_AUTOSEL &&
      step == 3'h3 |-> ##[1:10] (cycStart && cycReq.data == 8'hf0)) // see R07
    else $error("no reset after autoselect read");
  a_timeout_reset: assert property (timedOut |-> ##[1:10]
      (cycStart && !cycReq.isRead && cycReq.data == 8'hf0)) // see R08
    else $error("no reset after timeout flag");
  a_late_add: assert property (wrCtrl && idle && newOp == fcs_pkg::OP_SECTADD &&
      !winOpen |=> refused && idle) // see R19
    else $error("late sector add not refused");
  a_window_len: assert property ($rose(winOpen) |-> winOpen [*8]) // see R19
    else $error("erase window closed early");
  c_prog_done: cover property (pollEnd && pollOk && op == fcs_pkg::OP_PROGRAM);
  c_sector_add: cover property (accept && newOp == fcs_pkg::OP_SECTADD);
  c_timeout: cover property (timedOut);
endmodule
`default_nettype wire

// ### fcs_flash_model.sv
// behavioural flash device answering the host's pin cycles
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model #(
  parameter int PROG_NS = 500,
  parameter int ERASE_NS = 3000,
  parameter int WIN_NS = 2000,
  parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'hc3, // arbitrary value
  parameter logic [4:0] PROT_SECT = 5'h03
) (
  input wire logic [20:0] flashAddr,
  input wire logic [7:0] flashDqOut,
  output logic [7:0] flashDqIn,
  input wire logic flashDqOen,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashResetN,
  output logic flashReadyBusy,
  input wire logic failNext
);
  // modes: 0 read, 1 autoselect, 2 program, 3 erase, 4 window, 5 suspended
  int mode = 0;
  int step = 0;
  int ks[$];
  time doneAt = 0;
  logic [7:0] mem [int];
  logic [31:0] eraseSet = '0;
  logic [20:0] la = '0;
  logic [7:0] pdata = '0;
  logic [7:0] lastDrv = '0;
  logic [7:0] rdVal;
  logic tog = 1'b0;
  logic tmo = 1'b0;
  logic chip = 1'b0;
  wire logic wrOn = !flashCeN && !flashWeN;
  wire logic rdOn = !flashCeN && !flashOeN;
  // ------------------------------------------------------------------
  // command interpreter
  // ------------------------------------------------------------------
  task automatic take(input logic [20:0] a, input logic [7:0] d);
    logic u1;
    logic u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2aa;
    if (mode == 2 || (mode == 3 && chip)) begin
      if (tmo && d == 8'hf0) mode = 0;
    end else if (mode == 3) begin
      if (d == 8'hb0) mode = 5;
    end else if (mode == 4) begin
      if (d == 8'h30) begin
        eraseSet[a[20:16]] = 1'b1;
        doneAt = $time + WIN_NS;
      end else mode = d == 8'hb0 ? 5 : 0;
    end else if (mode == 5) begin
      if (d == 8'h30) mode = 3;
    end else if (d == 8'hf0) begin
      mode = 0;
      step = 0;
    end else if (mode == 1) step = 0;
    else if (step == 0 || step == 4) step = (u1 && d == 8'haa) ? step + 1 : 0;
    else if (step == 1 || step == 5) step = (u2 && d == 8'h55) ? step + 1 : 0;
    else if (step == 2 && u1 && d == 8'h90) begin
      mode = 1;
      step = 0;
    end else if (step == 2 && u1) step = d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
    else if (step == 3) begin
      step = 0;
      pdata = d;
      tmo = failNext;
      mem[int'(a)] = (mem.exists(int'(a)) ? mem[int'(a)] : 8'hff) & d;
      mode = 2;
      doneAt = $time + PROG_NS;
    end else if (step == 6 && (d == 8'h30 || (u1 && d == 8'h10))) begin
      step = 0;
      chip = d == 8'h10;
      tmo = 1'b0;
      eraseSet = '0;
      eraseSet[a[20:16]] = 1'b1;
      mode = chip ? 3 : 4;
      doneAt = $time + (chip ? ERASE_NS : WIN_NS);
    end else step = 0;
  endtask
  always @(posedge wrOn) la = flashAddr;
  always @(negedge wrOn) take(la, flashDqIn);
  always @(negedge flashResetN) begin
    mode = 0;
    step = 0;
    tmo = 1'b0;
  end
  // ------------------------------------------------------------------
  // embedded algorithms and read path
  // ------------------------------------------------------------------
  always #10 begin
    if ((mode == 2 || mode == 3) && !tmo && $time >= doneAt) begin
      ks.delete();
      foreach (mem[k]) if (mode == 3 && (chip || eraseSet[k >> 16])) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
      mode = 0;
    end else if (mode == 4 && $time >= doneAt) begin
      mode = 3;
      doneAt = $time + ERASE_NS;
    end
  end
  always @(posedge flashOeN) begin
    lastDrv = rdVal;
    tog = ~tog;
  end
  always @* begin
    if (mode == 0) rdVal = mem.exists(int'(flashAddr)) ? mem[int'(flashAddr)] : 8'hff;
    else if (mode == 1) rdVal = flashAddr[7:0] == 8'h00 ? MFR_ID : flashAddr[7:0] == 8'h01 ? DEV_ID
        : {7'h00, flashAddr[7:0] == 8'h02 && flashAddr[20:16] == PROT_SECT};
    else rdVal = {mode == 2 ? ~pdata[7] : 1'b0, tog, tmo, 5'h00};
    // released bus shows the inverse, never a stale copy
    flashDqIn = !flashDqOen ? flashDqOut : rdOn ? rdVal : ~lastDrv;
  end
  assign flashReadyBusy = !(mode == 2 || mode == 3 || mode == 4);
endmodule
`default_nettype wire

// ### fcs_pkg.sv
// constants, command bytes and carrier types of the flash command host
package fcs_pkg;
  localparam int CLK_MHZ = 40;
  localparam int AW = 21;
  localparam int DW = 8;
  // -------------------------------------------------------------------
  // flash pin timing
  // -------------------------------------------------------------------
  localparam int WE_LOW_NS = 35;
  localparam int RD_ACC_NS = 90;
  localparam int ERASE_WIN_US = 50;
  localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_ACC_CYC = (RD_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
  localparam int SYNC_CYC = 2;
  // -------------------------------------------------------------------
  // apb register map
  // -------------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_WIN = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_RYBY = 4;
  localparam int ST_RDATA = 8;
  // -------------------------------------------------------------------
  // command bytes and addresses
  // -------------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [20:0] UNLOCK_ADDR1 = 21'h000555;
  localparam logic [20:0] UNLOCK_ADDR2 = 21'h0002aa;
  localparam int POLL_BIT = 7;
  localparam int TIMEOUT_BIT = 5;
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
    OP_CHIP = 4'h4, OP_SECT = 4'h5, OP_SECTADD = 4'h6, OP_SUSPEND = 4'h7,
    OP_RESUME = 4'h8, OP_WAIT = 4'h9
  } fcs_op_t;
  typedef struct packed {
    logic isRead;
    logic [20:0] addr;
    logic [7:0] data;
  } fcs_cyc_t;
endpackage

// ### testbench.sv
// self-checking bench of the flash command host against the device model
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam logic [7:0] MFR = 8'h5a; // arbitrary value
  localparam logic [7:0] DEV = 8'hc3; // arbitrary value
  logic ref_clk, nrst, clkEn, psel, penable, pwrite, failNext, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [20:0] flashAddr;
  logic [7:0] flashDqOut, flashDqIn;
  logic flashDqOen, flashCeN, flashWeN, flashOeN, flashResetN, flashReadyBusy;
  logic [20:0] asAddr [4] = '{21'h1aa300, 21'h000701, 21'h030002, 21'h040002};
  logic [7:0] asExp [4] = '{MFR, DEV, 8'h01, 8'h00};
  int err_total = 0;
  int tests_run = 0;
  fcs_flash_host #(.WIN_CYC(40)) dut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqIn(flashDqIn), .flashDqOen(flashDqOen),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .flashResetN(flashResetN), .flashReadyBusy(flashReadyBusy));
  fcs_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) flash (.flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqIn(flashDqIn), .flashDqOen(flashDqOen),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .flashResetN(flashResetN), .flashReadyBusy(flashReadyBusy), .failNext(failNext));
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic op(input logic [3:0] c, input logic [20:0] a, input logic [7:0] d);
    apb(1'b1, fcs_pkg::REG_ADDR, {11'h000, a});
    apb(1'b1, fcs_pkg::REG_WDATA, {24'h000000, d});
    apb(1'b1, fcs_pkg::REG_CTRL, {28'h0000000, c});
  endtask
  task automatic wait_idle();
    do apb(1'b0, fcs_pkg::REG_STATUS, 32'h0); while (q[fcs_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic run(input logic [3:0] c, input logic [20:0] a, input logic [7:0] d);
    op(c, a, d);
    wait_idle();
  endtask
  task automatic expect_rd(input string nm, input logic [20:0] a, input logic [7:0] ex);
    run(fcs_pkg::OP_READ, a, 8'h00);
    `CHECK(nm, ex, q[15:8])
  endtask
  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // pin watch and sequence
  // ------------------------------------------------------------------
  // strobes settle after the launching edge, so look mid-cycle
  always @(negedge ref_clk) if (!flashWeN && !flashCeN) begin
    `CHECK("dq enable in write", 1'b0, flashDqOen)
    `CHECK("oe in write", 1'b1, flashOeN)
  end
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    {nrst, psel, penable, pwrite, failNext, paddr, pwdata} = '0;
    clkEn = 1'b1;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
    `CHECK("status after reset", 32'h00000010, q)
    apb(1'b0, 12'h010, 32'h0);
    `CHECK("unmapped error", 1'b1, e)
    apb(1'b1, fcs_pkg::REG_ADDR, 32'hffffffff);
    apb(1'b0, fcs_pkg::REG_ADDR, 32'h0);
    `CHECK("addr width", 32'h001fffff, q)
    run(fcs_pkg::OP_PROGRAM, 21'h012345, 8'h5a);
    `CHECK("programmed cell", 8'h5a, flash.mem[32'h12345])
    expect_rd("program read", 21'h012345, 8'h5a);
    run(fcs_pkg::OP_PROGRAM, 21'h012345, 8'h0f);
    expect_rd("clear only", 21'h012345, 8'h0a);
    for (int i = 0; i < 4; i++) begin
      run(fcs_pkg::OP_AUTOSEL, asAddr[i], 8'h00);
      `CHECK("ident byte", asExp[i], q[15:8])
      `CHECK("left autoselect", 0, flash.mode)
    end
    op(fcs_pkg::OP_CHIP, 21'h000000, 8'h00);
    apb(1'b1, fcs_pkg::REG_CTRL, 32'h00000001);
    wait_idle();
    `CHECK("refused while busy", 1'b1, q[fcs_pkg::ST_REFUSED])
    expect_rd("chip erased", 21'h012345, 8'hff);
    run(fcs_pkg::OP_PROGRAM, 21'h030010, 8'h00);
    run(fcs_pkg::OP_PROGRAM, 21'h050020, 8'h11);
    run(fcs_pkg::OP_SECT, 21'h030000, 8'h00);
    `CHECK("window open", 1'b1, q[fcs_pkg::ST_WIN])
    run(fcs_pkg::OP_SECTADD, 21'h05ffff, 8'h00);
    `CHECK("sector set", 32'h00000028, flash.eraseSet)
    run(fcs_pkg::OP_WAIT, 21'h030010, 8'h00);
    expect_rd("sector a erased", 21'h030010, 8'hff);
    expect_rd("sector b erased", 21'h050020, 8'hff);
    run(fcs_pkg::OP_SECTADD, 21'h050000, 8'h00);
    `CHECK("late add refused", 1'b1, q[fcs_pkg::ST_REFUSED])
    run(fcs_pkg::OP_SECT, 21'h060000, 8'h00);
    run(fcs_pkg::OP_RESET, 21'h000000, 8'h00);
    `CHECK("window cancelled", 0, flash.mode)
    `CHECK("window flag", 1'b0, q[fcs_pkg::ST_WIN])
    run(fcs_pkg::OP_SECT, 21'h060000, 8'h00);
    run(fcs_pkg::OP_SUSPEND, 21'h000000, 8'h00);
    `CHECK("suspended", 5, flash.mode)
    run(fcs_pkg::OP_RESUME, 21'h000000, 8'h00);
    `CHECK("resumed", 3, flash.mode)
    run(fcs_pkg::OP_WAIT, 21'h060000, 8'h00);
    `CHECK("erase done", 0, flash.mode)
    failNext <= 1'b1;
    run(fcs_pkg::OP_PROGRAM, 21'h070000, 8'h00);
    failNext <= 1'b0;
    `CHECK("timeout flagged", 1'b1, q[fcs_pkg::ST_ERR])
    `CHECK("timeout reset", 0, flash.mode)
    // enable low must hold the write in its setup cycle
    op(fcs_pkg::OP_RESET, 21'h000000, 8'h00);
    clkEn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHECK("frozen write", 1'b0, flashDqOen)
    clkEn <= 1'b1;
    wait_idle();
    op(fcs_pkg::OP_PROGRAM, 21'h070001, 8'h00);
    wait (flash.mode == 2);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    `CHECK("hard reset aborts", 0, flash.mode)
    expect_rd("read after abort", 21'h012345, 8'hff);
    print_verdict();
  end
endmodule
`default_nettype wire
